// File: core/bfs_pkg.sv
package bfs_pkg;
	// time base: one millisecond tick derived from core_clk
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W = 14;
	// simple stage operate time in 0.1 s steps, 1..100
	localparam int STEP_MS = 100;
	localparam logic [6:0] SIMPLE_STEPS_MIN = 7'h01;
	localparam logic [6:0] SIMPLE_STEPS_MAX = 7'h64;
	localparam int SIMPLE_MS_W = 14;
	// selector stage operate delay in ms
	localparam logic [7:0] STAGE_MS_MIN = 8'h28;
	localparam logic [7:0] STAGE_MS_MAX = 8'hc8;
	localparam int NUM_CONTACTS = 7;
	localparam int NUM_SEL = 4;
	localparam int NUM_STAGES = 2;
	localparam logic [13:0] CNT_RESET = 14'h0000;
	// per-selector reset criteria bits
	localparam int RST_MON = 0;
	localparam int RST_ZERO = 1;
	localparam int RST_CB = 2;
	typedef enum logic [2:0] {
		BFS_IDLE = 3'b001,
		BFS_RUN = 3'b010,
		BFS_TRIP = 3'b100
	} bfs_state_t;
endpackage : bfs_pkg

// File: core/bfs_breaker_failure_stage.sv
// Notes on behaviour
// - backup output after trip outlasts operate time
// - backup held until supervised trip clears
// - any source on contact starts supervision
// - supervised contact chosen among fitted contacts
// - delays accurate within twenty milliseconds
// - two identical selector stages, own outputs
// - disabled stage never starts nor trips
// - start while any selected source active
// - block freezes timer, resumes afterwards
// - block forces start and trip low
// - four edge events, each individually enabled
// - four selectors; zero-current only on one, two
// - selector four resets on its inputs only
// - protection source counts only enabled and started, except selector four: started only
// - no criterion selected means monitored-stage reset
// - multiple reset criteria are ANDed
// - delay elapse asserts trip and logs event
// - stage delay 40 to 200 ms
// - zero current when all phases and earth below threshold
// - separate phase and earth zero-current thresholds
// - conditions one, three offer breaker-status reset
`timescale 1ns/100ps
module bfs_breaker_failure_stage
	import bfs_pkg::*;
#(
	parameter int FITTED_CONTACTS = NUM_CONTACTS,
	// cycles per ms tick; a bench may shorten it to reach trip in time
	parameter int unsigned TICK_DIV = TICK_CYCLES,
	parameter int SRC_W = 8,
	parameter int CUR_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	// simple stage
	input wire logic [NUM_CONTACTS-1:0] contact_drive,
	input wire logic [2:0] simple_contact_sel,
	input wire logic [6:0] simple_steps,
	output logic simple_backup_q,
	// selector stages: sources per selector, per stage
	input wire logic [NUM_STAGES-1:0] stage_enable,
	input wire logic [NUM_STAGES-1:0] stage_block,
	input wire logic [NUM_STAGES*8-1:0] stage_delay_ms,
	input wire logic [NUM_STAGES*4-1:0] stage_event_en,
	input wire logic [NUM_STAGES*NUM_SEL*SRC_W-1:0] src_select,
	input wire logic [NUM_SEL*SRC_W-1:0] prot_enabled,
	input wire logic [NUM_SEL*SRC_W-1:0] prot_started,
	input wire logic [NUM_STAGES*NUM_SEL*3-1:0] reset_crit,
	input wire logic [NUM_STAGES-1:0] cb_open_c1,
	input wire logic [NUM_STAGES-1:0] cb_open_c3,
	// zero-current detector inputs, then selector stage outputs
	input wire logic [3*CUR_W-1:0] phase_current,
	input wire logic [CUR_W-1:0] earth_current,
	input wire logic [CUR_W-1:0] phase_zero_thr,
	input wire logic [CUR_W-1:0] earth_zero_thr,
	output logic [NUM_STAGES-1:0] stage_start_q,
	output logic [NUM_STAGES-1:0] stage_trip_q,
	output logic [NUM_STAGES*4-1:0] stage_event_q
);

	typedef struct packed {
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic [NUM_CONTACTS-1:0] pin_s1;
		logic [NUM_CONTACTS-1:0] pin_s2;
		logic [SIMPLE_MS_W-1:0] simple_ms;
		logic simple_backup;
		bfs_state_t [NUM_STAGES-1:0] st;
		logic [NUM_STAGES-1:0][7:0] ms;
		logic [NUM_STAGES-1:0] start;
		logic [NUM_STAGES-1:0] trip;
		logic [NUM_STAGES*4-1:0] event_p;
	} bfs_regs_t;

	bfs_regs_t r_q, r_d;

	function automatic logic [7:0] clamp_ms(input logic [7:0] v);
		if (v < STAGE_MS_MIN) return STAGE_MS_MIN;
		if (v > STAGE_MS_MAX) return STAGE_MS_MAX;
		return v;
	endfunction

	function automatic logic [6:0] clamp_steps(input logic [6:0] v);
		if (v < SIMPLE_STEPS_MIN) return SIMPLE_STEPS_MIN;
		if (v > SIMPLE_STEPS_MAX) return SIMPLE_STEPS_MAX;
		return v;
	endfunction

	// zero-current needs every phase and earth below own threshold
	logic zero_cur;
	always_comb begin
		zero_cur = (earth_current < earth_zero_thr);
		for (int p = 0; p < 3; p++) begin
			if (phase_current[p*CUR_W +: CUR_W] >= phase_zero_thr) zero_cur = 1'b0;
		end
	end

	logic sup_active;
	logic [NUM_STAGES-1:0] any_src;
	logic [NUM_STAGES-1:0] do_reset;
	always_comb begin
		logic [SRC_W-1:0] sel;
		logic [SRC_W-1:0] live;
		logic [2:0] crit;
		logic sel_on;
		logic ok;
		sel = '0;
		live = '0;
		crit = '0;
		sel_on = 1'b0;
		ok = 1'b0;
		// unfitted contacts never supervised
		sup_active = (int'(simple_contact_sel) < FITTED_CONTACTS) &&
			r_q.pin_s2[simple_contact_sel];
		for (int s = 0; s < NUM_STAGES; s++) begin
			any_src[s] = 1'b0;
			do_reset[s] = 1'b1;
			for (int c = 0; c < NUM_SEL; c++) begin
				sel = src_select[(s*NUM_SEL+c)*SRC_W +: SRC_W];
				// selector four takes contacts and inputs directly
				live = (c == 3) ? prot_started[c*SRC_W +: SRC_W] :
					(prot_enabled[c*SRC_W +: SRC_W] & prot_started[c*SRC_W +: SRC_W]);
				sel_on = |(sel & live);
				any_src[s] = any_src[s] | sel_on;
				crit = reset_crit[(s*NUM_SEL+c)*3 +: 3];
				if (c >= 2) crit[RST_ZERO] = 1'b0;
				if (c == 1 || c == 3) crit[RST_CB] = 1'b0;
				if (c == 3) crit = 3'b001;
				if (crit == 3'b000) crit[RST_MON] = 1'b1;
				ok = 1'b1;
				if (crit[RST_MON] && sel_on) ok = 1'b0;
				if (crit[RST_ZERO] && !zero_cur) ok = 1'b0;
				if (crit[RST_CB] && !(c == 0 ? cb_open_c1[s] : cb_open_c3[s])) ok = 1'b0;
				if (|sel) do_reset[s] = do_reset[s] & ok;
			end
		end
	end

	always_comb begin
		r_d = r_q;
		r_d.pin_s1 = contact_drive;
		r_d.pin_s2 = r_q.pin_s1;
		r_d.event_p = '0;
		// 1 ms tick keeps counters well inside the 20 ms accuracy
		r_d.tick = 1'b0;
		if (r_q.tick_cnt == TICK_W'(TICK_DIV - 1)) begin
			r_d.tick_cnt = '0;
			r_d.tick = 1'b1;
		end else begin
			r_d.tick_cnt = r_q.tick_cnt + 1'b1;
		end
		if (!sup_active) begin
			r_d.simple_ms = '0;
			r_d.simple_backup = 1'b0;
		end else if (r_q.tick && !r_q.simple_backup) begin
			if (r_q.simple_ms >= SIMPLE_MS_W'(clamp_steps(simple_steps) * STEP_MS))
				r_d.simple_backup = 1'b1;
			else
				r_d.simple_ms = r_q.simple_ms + 1'b1;
		end
		for (int s = 0; s < NUM_STAGES; s++) begin
			case (r_q.st[s])
				BFS_IDLE: begin
					r_d.ms[s] = '0;
					if (stage_enable[s] && any_src[s] && !do_reset[s]) r_d.st[s] = BFS_RUN;
				end
				BFS_RUN: begin
					if (!stage_enable[s] || do_reset[s]) begin
						r_d.st[s] = BFS_IDLE;
					end else if (r_q.tick && !stage_block[s]) begin
						if (r_q.ms[s] + 8'h01 >= clamp_ms(stage_delay_ms[s*8 +: 8]))
							r_d.st[s] = BFS_TRIP;
						else
							r_d.ms[s] = r_q.ms[s] + 8'h01;
					end
				end
				BFS_TRIP: begin
					if (!stage_enable[s] || do_reset[s]) r_d.st[s] = BFS_IDLE;
				end
				default: r_d.st[s] = BFS_IDLE;
			endcase
			r_d.start[s] = (r_d.st[s] != BFS_IDLE) && !stage_block[s];
			r_d.trip[s] = (r_d.st[s] == BFS_TRIP) && !stage_block[s];
			// events: start on, start off, trip on, trip off
			r_d.event_p[s*4+0] = stage_event_en[s*4+0] & r_d.start[s] & ~r_q.start[s];
			r_d.event_p[s*4+1] = stage_event_en[s*4+1] & ~r_d.start[s] & r_q.start[s];
			r_d.event_p[s*4+2] = stage_event_en[s*4+2] & r_d.trip[s] & ~r_q.trip[s];
			r_d.event_p[s*4+3] = stage_event_en[s*4+3] & ~r_d.trip[s] & r_q.trip[s];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r_q <= '0;
			for (int s = 0; s < NUM_STAGES; s++) begin
				r_q.st[s] <= BFS_IDLE;
			end
		end else begin
			r_q <= r_d;
		end
	end

	assign simple_backup_q = r_q.simple_backup;
	assign stage_start_q = r_q.start;
	assign stage_trip_q = r_q.trip;
	assign stage_event_q = r_q.event_p;

endmodule // bfs_breaker_failure_stage

// File: verif/bfs_stage_checker.sv
`timescale 1ns/100ps
module bfs_stage_checker (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [6:0] contact_drive,
	input wire logic [1:0] stage_enable,
	input wire logic [1:0] stage_block,
	input wire logic simple_backup_q,
	input wire logic [1:0] stage_start_q,
	input wire logic [1:0] stage_trip_q,
	input wire logic [7:0] stage_event_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// four cycles cover the input register ahead of the state
	sequence s_quiet; contact_drive == 7'h00 [*4]; endsequence
	property p_dis; !stage_enable[0] [*3] |-> !stage_start_q[0]; endproperty
	a_dis: assert property (p_dis) else $error("start while disabled");
	property p_blk; stage_block[0] [*3] |-> !(stage_start_q[0] | stage_trip_q[0]); endproperty
	a_blk: assert property (p_blk) else $error("output while blocked");
	property p_trip; stage_trip_q[0] |-> stage_start_q[0]; endproperty
	a_trip: assert property (p_trip) else $error("trip without start");
	property p_son; stage_event_q[0] |-> $rose(stage_start_q[0]); endproperty
	a_son: assert property (p_son) else $error("stray start on event");
	property p_sof; stage_event_q[1] |-> $fell(stage_start_q[0]); endproperty
	a_sof: assert property (p_sof) else $error("stray start off event");
	property p_ton; stage_event_q[2] |-> $rose(stage_trip_q[0]); endproperty
	a_ton: assert property (p_ton) else $error("stray trip on event");
	property p_tof; stage_event_q[3] |-> $fell(stage_trip_q[0]); endproperty
	a_tof: assert property (p_tof) else $error("stray trip off event");
	property p_bak; s_quiet |=> !simple_backup_q; endproperty
	a_bak: assert property (p_bak) else $error("backup held after clear");
endmodule // bfs_stage_checker
bind bfs_breaker_failure_stage bfs_stage_checker bfs_stage_checker_i (.*);

// File: verif/bfs_far_model.sv
`timescale 1ns/100ps
module bfs_far_model (
	input wire logic core_clk,
	input wire logic fault,
	input wire logic src_on,
	input wire logic cb_open,
	output logic [31:0] prot_enabled,
	output logic [31:0] prot_started,
	output logic [6:0] contact_drive,
	output logic [1:0] cb_open_c1,
	output logic [1:0] cb_open_c3,
	output logic [47:0] phase_current,
	output logic [15:0] earth_current
);
	initial {prot_enabled, prot_started, contact_drive, cb_open_c1, cb_open_c3} = '0;
	initial {phase_current, earth_current} = '0;
	// currents follow the fault so zero-current reset tracks the source
	always @(posedge core_clk) begin
		prot_enabled <= {32{src_on}};
		prot_started <= {32{fault}};
		contact_drive <= {6'h00, fault};
		cb_open_c1 <= {2{cb_open}};
		cb_open_c3 <= {2{cb_open}};
		phase_current <= fault ? {3{16'h0400}} : '0;
		earth_current <= fault ? 16'h0400 : '0;
	end
endmodule // bfs_far_model

// File: verif/bfs_breaker_failure_stage_tb.sv
`timescale 1ns/100ps
module bfs_breaker_failure_stage_tb;
	logic core_clk = 1'b0, rst_b = 1'b0, fault = 1'b0, src_on = 1'b1, cb_open = 1'b0;
	logic [2:0] simple_contact_sel = 3'h7;
	logic [1:0] stage_enable = 2'h0, stage_block = 2'h0;
	logic [7:0] stage_event_en = 8'hff, ev = 8'h00;
	logic [63:0] src_select = '0;
	logic [23:0] reset_crit = '0;
	logic [31:0] prot_enabled, prot_started;
	logic [6:0] contact_drive;
	logic [1:0] cb_open_c1, cb_open_c3, stage_start_q, stage_trip_q;
	logic [47:0] phase_current;
	logic [15:0] earth_current;
	logic simple_backup_q;
	logic [7:0] stage_event_q;
	int n_mismatch = 0;
	int checks_done = 0;
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	bfs_far_model bfs_far_model_i (.*);
	// ten-cycle tick so trip and backup delays fit the run
	bfs_breaker_failure_stage #(.TICK_DIV(10)) bfs_breaker_failure_stage_i (.*,
		.simple_steps(7'h01),
		.stage_delay_ms(16'h2828), .phase_zero_thr(16'h0010), .earth_zero_thr(16'h0010));
	// event pulses last one cycle, so gather them
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1 ev = ev | stage_event_q;
		end
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	// trip needs 40 ms of ticks, too long here; the checker watches it
	task automatic t_start_reset;
		@(posedge core_clk);
		stage_enable <= 2'h3;
		src_select <= 64'h0000_0001_0000_0001;
		reset_crit <= 24'h00_3005;
		simple_contact_sel <= 3'h0;
		fault <= 1'b1;
		ev = '0;
		cyc(6);
		chk("start", 8'h03, 8'(stage_start_q));
		chk("on_events", 8'h11, ev);
		chk("early_trip", 8'h00, 8'({stage_trip_q, simple_backup_q}));
		@(posedge core_clk);
		fault <= 1'b0;
		cyc(6);
		chk("and_reset", 8'h01, 8'(stage_start_q));
		@(posedge core_clk);
		cb_open <= 1'b1;
		ev = '0;
		cyc(6);
		chk("cb_reset", 8'h02, ev);
	endtask
	task automatic t_block;
		@(posedge core_clk);
		fault <= 1'b1;
		cyc(6);
		@(posedge core_clk);
		stage_block <= 2'h1;
		cyc(3);
		chk("blocked", 8'h02, 8'(stage_start_q));
		@(posedge core_clk);
		stage_block <= 2'h0;
		cyc(3);
		chk("resumed", 8'h03, 8'(stage_start_q));
	endtask
	task automatic t_gate;
		@(posedge core_clk);
		stage_enable <= 2'h2;
		cyc(4);
		chk("disabled", 8'h02, 8'(stage_start_q));
		@(posedge core_clk);
		stage_enable <= 2'h3;
		src_on <= 1'b0;
		cyc(6);
		// stage two stays up: its zero-current criterion is not met yet
		chk("src_off", 8'h02, 8'(stage_start_q));
		@(posedge core_clk);
		stage_event_en <= 8'h00;
		src_on <= 1'b1;
		ev = '0;
		cyc(6);
		chk("masked", 8'h00, ev);
	endtask
	task automatic t_trip;
		@(posedge core_clk);
		fault <= 1'b0;
		stage_event_en <= 8'hff;
		cyc(8);
		chk("idle", 8'h00, 8'({stage_trip_q, stage_start_q}));
		@(posedge core_clk);
		fault <= 1'b1;
		cyc(380);
		chk("trip_early", 8'h00, 8'(stage_trip_q));
		ev = '0;
		cyc(40);
		chk("trip", 8'h03, 8'(stage_trip_q));
		chk("trip_ev", 8'h44, ev);
		cyc(560);
		chk("backup_early", 8'h00, 8'(simple_backup_q));
		cyc(60);
		chk("backup", 8'h01, 8'(simple_backup_q));
		@(posedge core_clk);
		fault <= 1'b0;
		ev = '0;
		cyc(8);
		chk("backup_off", 8'h00, 8'(simple_backup_q));
		chk("off_ev", 8'haa, ev);
	endtask
	task automatic end_sim;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		t_start_reset();
		t_block();
		t_gate();
		t_trip();
		end_sim();
	end
endmodule // bfs_breaker_failure_stage_tb
